// ### rtl/spvp_pkg.sv
// spvp_pkg: constants and types for the serial program/verify port
package spvp_pkg;
  localparam int CLK_HZ = 20_000_000;
  // link framing
  localparam logic [3:0] CMD_LAST = 4'h5;
  localparam logic [3:0] DATA_LAST = 4'hF;
  localparam logic [3:0] RD_DRIVE_FROM = 4'h1;
  localparam int DW_LO = 1;
  localparam int DW_HI = 14;
  localparam int DB_HI = 8;
  localparam int WORD_BITS = 14;
  localparam int BYTE_BITS = 8;
  // memory geometry
  localparam int PM_AW = 11;
  localparam int CFG_AW = 4;
  localparam int DM_AW = 7;
  localparam int PM_WORDS = 2048;
  localparam int CFG_WORDS = 16;
  localparam int DM_BYTES = 128;
  // program counter
  localparam logic [13:0] PC_RESET = 14'h0000;
  localparam logic [13:0] PC_CFG_BASE = 14'h2000;
  localparam logic [12:0] PC_STEP = 13'h0001;
  localparam logic [8:0] CFG_ROW_ZERO = 9'h000;
  localparam logic [3:0] CFG_LAST_USABLE = 4'h7;
  localparam logic [3:0] CFG_WORD_IDX = 4'h7;
  // configuration word fields
  localparam int CFG_CP_HI = 13;
  localparam int CFG_CP_LO = 12;
  localparam int CFG_CPD_BIT = 8;
  localparam int CFG_LVEN_BIT = 7;
  localparam logic [1:0] CP_OFF = 2'h3;
  localparam logic [13:0] WORD_ERASED = 14'h3FFF;
  localparam logic [7:0] BYTE_ERASED = 8'hFF;
  // timing
  localparam int ERASE_TIME_US = 4000;
  localparam int PROG_TIME_US = 4000;
  localparam int ERASE_CYCLES = ERASE_TIME_US * (CLK_HZ / 1_000_000);
  localparam int PROG_CYCLES = PROG_TIME_US * (CLK_HZ / 1_000_000);
  localparam int CNT_W = 18;
  // command codes, low nibble where the top two bits are don't-care
  localparam logic [3:0] OP_LD_CFG = 4'h0;
  localparam logic [3:0] OP_LD_PM = 4'h2;
  localparam logic [3:0] OP_LD_DM = 4'hA;
  localparam logic [3:0] OP_INC = 4'h6;
  localparam logic [3:0] OP_RD_PM = 4'h4;
  localparam logic [3:0] OP_RD_DM = 4'h5;
  localparam logic [3:0] OP_BE_PM = 4'h9;
  localparam logic [3:0] OP_BE_DM = 4'hB;
  localparam logic [5:0] OP_BEGIN_EP = 6'h08;
  localparam logic [5:0] OP_BEGIN_P = 6'h18;
  localparam logic [5:0] OP_SETUP1 = 6'h03;
  localparam logic [5:0] OP_SETUP2 = 6'h07;
  typedef enum {CMD_NONE, CMD_LD_CFG, CMD_LD_PM, CMD_LD_DM, CMD_INC, CMD_RD_PM, CMD_RD_DM,
                CMD_BEGIN_EP, CMD_BEGIN_P, CMD_BE_PM, CMD_BE_DM, CMD_SETUP1, CMD_SETUP2} spvp_cmd_t;
  typedef enum {JOB_WORD_EP, JOB_WORD_P, JOB_BULK_PM, JOB_BULK_DM, JOB_CHIP} spvp_job_t;
  typedef enum {ST_CMD, ST_LOAD, ST_READ} spvp_state_t;
  typedef struct packed {
    logic hv;
    logic sel;
    logic lv;
    logic sclk;
    logic sdat;
  } spvp_pins_t;
endpackage

// ### rtl/spvp_port.sv
// spvp_port: serial program/verify port with its memory arrays
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - sample data on serial clock falling edges
// - six-bit command, data phase for loads/reads
// - command and data shifted LSB first
// - data word is 0, 14 bits, 0
// - load config sets counter; load program word
// - load data byte, full 16 clocks
// - increment command advances the counter
// - read program/config word or data byte
// - drive from second rise, release after sixteenth
// - data byte read padded with zeros
// - erase then program loaded word, timed
// - program-only cycle writes without erase
// - bulk erase program or data memory
// - setup pair erases program, configuration and data memory
// - counter wraps within its half
// - configuration half sticky until mode re-entry
// - config rows to 0x200F, beyond maps user
// - ID words readable despite code protection
// - mode entry clears counter, other logic reset
// - low-voltage mode not overridden by high voltage
// - low-voltage entry only when enable bit set
module spvp_port #(
  parameter int ERASE_CYC = spvp_pkg::ERASE_CYCLES,
  parameter int PROG_CYC  = spvp_pkg::PROG_CYCLES
) (
  // clock, reset, enable
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  // programming pins
  input  wire logic mode_hv_i,
  input  wire logic mode_select_pin_i,
  input  wire logic low_voltage_entry_pin_i,
  input  wire logic serial_clock_pin_i,
  input  wire logic serial_data_pin_i,
  // data pin drive
  output logic      serial_data_pin_o,
  output logic      serial_data_pin_oe_n_o,
  // status
  output logic      pv_mode_o,
  output logic      low_voltage_programming_mode_o,
  output logic      busy_o
);
  import spvp_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  spvp_pins_t        pins_raw;
  spvp_pins_t        pins_s1_reg;
  spvp_pins_t        pins_s2_reg;
  logic              sclk_d_reg;
  logic              pv_mode_reg;
  logic              lv_mode_reg;
  logic              lv_go;
  logic              hv_go;
  logic              enter;
  logic              fall;
  logic              rise;
  spvp_state_t       state_reg;
  logic [3:0]        bit_cnt_reg;
  logic [5:0]        cmd_sh_reg;
  logic [15:0]       dat_sh_reg;
  logic [5:0]        cmd_now;
  logic [15:0]       word_now;
  spvp_cmd_t         cmd_kind;
  spvp_cmd_t         kind_reg;
  logic              cmd_done;
  logic              data_done;
  logic [13:0]       program_counter_reg;
  logic [13:0]       latch_reg;
  logic              latch_dm_reg;
  logic              setup1_seen_reg;
  logic              busy_reg;
  logic [CNT_W-1:0]  busy_cnt_reg;
  spvp_job_t         job_reg;
  logic              commit;
  logic [3:0]        rise_cnt_reg;
  logic [15:0]       rd_word_reg;
  logic              rd_dm_reg;
  logic              sdat_o_reg;
  logic              sdat_oe_n_reg;
  logic [13:0]       pm_rd;
  logic [7:0]        dm_rd;
  logic              cfg_row;
  logic              user_locked;
  logic              data_locked;
  logic              lv_enable;
  logic [WORD_BITS-1:0] pm_mem [PM_WORDS];
  logic [WORD_BITS-1:0] cfg_mem [CFG_WORDS];
  logic [BYTE_BITS-1:0] dm_mem [DM_BYTES];

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic is_cfg_row(input logic [13:0] a);
    return a[13] && (a[12:4] == CFG_ROW_ZERO);
  endfunction

  function automatic logic [13:0] pc_inc(input logic [13:0] a);
    return {a[13], a[12:0] + PC_STEP};
  endfunction

  function automatic spvp_cmd_t cmd_decode(input logic [5:0] c);
    spvp_cmd_t k;
    k = CMD_NONE;
    if (c == OP_BEGIN_EP) k = CMD_BEGIN_EP;
    else if (c == OP_BEGIN_P) k = CMD_BEGIN_P;
    else if (c == OP_SETUP1) k = CMD_SETUP1;
    else if (c == OP_SETUP2) k = CMD_SETUP2;
    else begin
      case (c[3:0])
        OP_LD_CFG: k = CMD_LD_CFG;
        OP_LD_PM: k = CMD_LD_PM;
        OP_LD_DM: k = CMD_LD_DM;
        OP_INC: k = CMD_INC;
        OP_RD_PM: k = CMD_RD_PM;
        OP_RD_DM: k = CMD_RD_DM;
        OP_BE_PM: k = CMD_BE_PM;
        OP_BE_DM: k = CMD_BE_DM;
        default: k = CMD_NONE;
      endcase
    end
    return k;
  endfunction

  // ----------------------------------------
  // pin synchronisers and edge finding
  // ----------------------------------------
  assign pins_raw = {mode_hv_i, mode_select_pin_i, low_voltage_entry_pin_i,
                     serial_clock_pin_i, serial_data_pin_i};

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pins_s1_reg <= '0;
      pins_s2_reg <= '0;
      sclk_d_reg <= 1'b0;
    end else if (ce_i) begin
      pins_s1_reg <= pins_raw;
      pins_s2_reg <= pins_s1_reg;
      sclk_d_reg <= pins_s2_reg.sclk;
    end
  end

  assign fall = pv_mode_reg & sclk_d_reg & ~pins_s2_reg.sclk;
  assign rise = pv_mode_reg & ~sclk_d_reg & pins_s2_reg.sclk;

  // ----------------------------------------
  // mode entry and exit
  // ----------------------------------------
  assign lv_enable = cfg_mem[CFG_WORD_IDX][CFG_LVEN_BIT];
  assign lv_go = lv_enable & pins_s2_reg.sel & pins_s2_reg.lv;
  // clock and data must be low while the high voltage arrives
  assign hv_go = pins_s2_reg.hv & ~pins_s2_reg.sclk & ~pins_s2_reg.sdat;
  assign enter = ce_i & ~pv_mode_reg & (lv_go | hv_go);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pv_mode_reg <= 1'b0;
      lv_mode_reg <= 1'b0;
    end else if (ce_i) begin
      if (!pv_mode_reg) begin
        pv_mode_reg <= lv_go | hv_go;
        lv_mode_reg <= lv_go;
      // high voltage is not looked at once low-voltage mode holds
      end else if (lv_mode_reg ? !(pins_s2_reg.sel && pins_s2_reg.lv) : !pins_s2_reg.hv) begin
        pv_mode_reg <= 1'b0;
        lv_mode_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // command and data shifter
  // ----------------------------------------
  assign cmd_now = {pins_s2_reg.sdat, cmd_sh_reg[5:1]};
  assign word_now = {pins_s2_reg.sdat, dat_sh_reg[15:1]};
  assign cmd_kind = cmd_decode(cmd_now);
  assign cmd_done = ce_i & fall & (state_reg == ST_CMD) & (bit_cnt_reg == CMD_LAST);
  assign data_done = ce_i & fall & (state_reg != ST_CMD) & (bit_cnt_reg == DATA_LAST);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || (ce_i && !pv_mode_reg)) begin
      state_reg <= ST_CMD;
      bit_cnt_reg <= '0;
      cmd_sh_reg <= '0;
      dat_sh_reg <= '0;
      kind_reg <= CMD_NONE;
    end else if (ce_i && fall) begin
      unique case (state_reg)
        ST_CMD: begin
          cmd_sh_reg <= cmd_now;
          if (bit_cnt_reg == CMD_LAST) begin
            bit_cnt_reg <= '0;
            kind_reg <= cmd_kind;
            // only loads and reads own a data phase
            unique case (cmd_kind)
              CMD_LD_CFG, CMD_LD_PM, CMD_LD_DM: state_reg <= ST_LOAD;
              CMD_RD_PM, CMD_RD_DM: state_reg <= ST_READ;
              default: state_reg <= ST_CMD;
            endcase
          end else begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
        end
        ST_LOAD, ST_READ: begin
          dat_sh_reg <= word_now;
          // the byte load still needs every one of the 16 clocks
          if (bit_cnt_reg == DATA_LAST) begin
            bit_cnt_reg <= '0;
            state_reg <= ST_CMD;
          end else begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // program counter
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || enter) begin
      program_counter_reg <= PC_RESET;
    end else if (ce_i) begin
      if (cmd_done && cmd_kind == CMD_INC) begin
        // top bit is kept, so each half wraps onto itself
        program_counter_reg <= pc_inc(program_counter_reg);
      end else if (data_done && kind_reg == CMD_LD_CFG) begin
        program_counter_reg <= PC_CFG_BASE;
      end
    end
  end

  // ----------------------------------------
  // load latch
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || enter) begin
      latch_reg <= '0;
      latch_dm_reg <= 1'b0;
    end else if (data_done && state_reg == ST_LOAD) begin
      // start and stop bits are dropped, the middle 14 bits kept (only the low 8 of them for a data byte)
      if (kind_reg == CMD_LD_DM) begin
        latch_reg <= {{(WORD_BITS-BYTE_BITS){1'b0}}, word_now[DB_HI:DW_LO]};
        latch_dm_reg <= 1'b1;
      end else begin
        latch_reg <= word_now[DW_HI:DW_LO];
        latch_dm_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // address decode and protection
  // ----------------------------------------
  assign cfg_row = is_cfg_row(program_counter_reg);
  assign user_locked = cfg_mem[CFG_WORD_IDX][CFG_CP_HI:CFG_CP_LO] != CP_OFF;
  assign data_locked = ~cfg_mem[CFG_WORD_IDX][CFG_CPD_BIT];

  always_comb begin
    // ID and config rows bypass code protection
    if (cfg_row) pm_rd = cfg_mem[program_counter_reg[CFG_AW-1:0]];
    else if (user_locked) pm_rd = '0;
    else pm_rd = pm_mem[program_counter_reg[PM_AW-1:0]];
    dm_rd = data_locked ? '0 : dm_mem[program_counter_reg[DM_AW-1:0]];
  end

  // ----------------------------------------
  // timed erase and write cycles
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || (ce_i && !pv_mode_reg)) begin
      busy_reg <= 1'b0;
      busy_cnt_reg <= '0;
      job_reg <= JOB_WORD_P;
      setup1_seen_reg <= 1'b0;
    end else if (ce_i) begin
      if (cmd_done) setup1_seen_reg <= (cmd_kind == CMD_SETUP1);
      if (busy_reg) begin
        busy_cnt_reg <= busy_cnt_reg - 1'b1;
        if (busy_cnt_reg == 1) busy_reg <= 1'b0;
      // a new array command during a cycle is dropped
      end else if (cmd_done) begin
        unique case (cmd_kind)
          CMD_BEGIN_EP: begin
            busy_reg <= 1'b1;
            busy_cnt_reg <= CNT_W'(ERASE_CYC + PROG_CYC);
            job_reg <= JOB_WORD_EP;
          end
          CMD_BEGIN_P: begin
            busy_reg <= 1'b1;
            busy_cnt_reg <= CNT_W'(PROG_CYC);
            job_reg <= JOB_WORD_P;
          end
          CMD_BE_PM: begin
            busy_reg <= !user_locked;
            busy_cnt_reg <= CNT_W'(ERASE_CYC);
            job_reg <= JOB_BULK_PM;
          end
          CMD_BE_DM: begin
            busy_reg <= !data_locked;
            busy_cnt_reg <= CNT_W'(ERASE_CYC);
            job_reg <= JOB_BULK_DM;
          end
          CMD_SETUP2: begin
            busy_reg <= setup1_seen_reg;
            busy_cnt_reg <= CNT_W'(ERASE_CYC);
            job_reg <= JOB_CHIP;
          end
          default: begin
            busy_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // leaving the mode mid-cycle abandons the write
  assign commit = ce_i & pv_mode_reg & busy_reg & (busy_cnt_reg == 1);

  // arrays are nonvolatile contents, so they carry no reset
  always_ff @(posedge ref_clk_i) begin
    if (commit) begin
      unique case (job_reg)
        JOB_WORD_EP, JOB_WORD_P: begin
          // the word written is the one loaded just before
          if (latch_dm_reg) begin
            dm_mem[program_counter_reg[DM_AW-1:0]] <= (job_reg == JOB_WORD_EP) ?
              latch_reg[BYTE_BITS-1:0] :
              (dm_mem[program_counter_reg[DM_AW-1:0]] & latch_reg[BYTE_BITS-1:0]);
          end else if (cfg_row) begin
            if (program_counter_reg[CFG_AW-1:0] <= CFG_LAST_USABLE) begin
              cfg_mem[program_counter_reg[CFG_AW-1:0]] <= (job_reg == JOB_WORD_EP) ? latch_reg :
                (cfg_mem[program_counter_reg[CFG_AW-1:0]] & latch_reg);
            end
          end else begin
            // without an erase, programming can only clear bits
            pm_mem[program_counter_reg[PM_AW-1:0]] <= (job_reg == JOB_WORD_EP) ? latch_reg :
              (pm_mem[program_counter_reg[PM_AW-1:0]] & latch_reg);
          end
        end
        JOB_BULK_PM: begin
          for (int i = 0; i < PM_WORDS; i++) pm_mem[i] <= WORD_ERASED;
          if (cfg_row) begin
            for (int i = 0; i < int'(CFG_WORD_IDX); i++) cfg_mem[i] <= WORD_ERASED;
          end
        end
        JOB_BULK_DM: begin
          for (int i = 0; i < DM_BYTES; i++) dm_mem[i] <= BYTE_ERASED;
        end
        JOB_CHIP: begin
          for (int i = 0; i < PM_WORDS; i++) pm_mem[i] <= WORD_ERASED;
          for (int i = 0; i < CFG_WORDS; i++) cfg_mem[i] <= WORD_ERASED;
          for (int i = 0; i < DM_BYTES; i++) dm_mem[i] <= BYTE_ERASED;
        end
      endcase
    end
  end

  // ----------------------------------------
  // read data phase
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || (ce_i && !pv_mode_reg)) begin
      rise_cnt_reg <= '0;
      rd_word_reg <= '0;
      rd_dm_reg <= 1'b0;
      sdat_o_reg <= 1'b0;
      sdat_oe_n_reg <= 1'b1;
    end else if (ce_i) begin
      if (cmd_done) begin
        rise_cnt_reg <= '0;
        rd_dm_reg <= (cmd_kind == CMD_RD_DM);
        if (cmd_kind == CMD_RD_DM) begin
          rd_word_reg <= {1'b0, {(WORD_BITS-BYTE_BITS){1'b0}}, dm_rd, 1'b0};
        end else begin
          rd_word_reg <= {1'b0, pm_rd, 1'b0};
        end
      end else if (state_reg == ST_READ && rise) begin
        sdat_o_reg <= rd_word_reg[rise_cnt_reg];
        // held at the last bit, a wrap to zero would look like a fresh frame while still driving
        if (rise_cnt_reg != DATA_LAST) rise_cnt_reg <= rise_cnt_reg + 4'h1;
        // first rise carries the start bit, pin turns at the second
        if (rise_cnt_reg >= RD_DRIVE_FROM) sdat_oe_n_reg <= 1'b0;
      end else if (data_done && state_reg == ST_READ) begin
        sdat_oe_n_reg <= 1'b1;
      end
    end
  end

  assign serial_data_pin_o = sdat_o_reg;
  assign serial_data_pin_oe_n_o = sdat_oe_n_reg;
  assign pv_mode_o = pv_mode_reg;
  assign low_voltage_programming_mode_o = lv_mode_reg;
  assign busy_o = busy_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_entry_clears_counter: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    enter |=> program_counter_reg == PC_RESET)
    else $error("counter not cleared on mode entry");

  chk_cfg_half_sticky: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (pv_mode_reg && program_counter_reg[13]) |=> program_counter_reg[13])
    else $error("counter left configuration half");

  chk_increment_step: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cmd_done && cmd_kind == CMD_INC) |=>
      program_counter_reg == pc_inc($past(program_counter_reg)))
    else $error("increment did not advance counter by one");

  chk_load_cfg_base: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (data_done && kind_reg == CMD_LD_CFG) |=> program_counter_reg == PC_CFG_BASE)
    else $error("load configuration did not set counter");

  chk_drive_only_read: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !serial_data_pin_oe_n_o |-> state_reg == ST_READ && rise_cnt_reg >= 4'h2)
    else $error("data pin driven outside read window");

  chk_release_at_end: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (data_done && state_reg == ST_READ) |=> serial_data_pin_oe_n_o [*2])
    else $error("data pin not released after read");

  chk_byte_padding: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!serial_data_pin_oe_n_o && rd_dm_reg && rise_cnt_reg > 4'h9) |-> !serial_data_pin_o)
    else $error("data byte read not zero padded");

  chk_falling_sample: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && fall && state_reg == ST_CMD && !enter) |=>
      cmd_sh_reg[5] == $past(pins_s2_reg.sdat))
    else $error("command bit not sampled on falling edge");

  chk_busy_countdown: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && pv_mode_reg && busy_reg && busy_cnt_reg > 1) |=>
      busy_reg && busy_cnt_reg == $past(busy_cnt_reg) - 1'b1)
    else $error("timed cycle restarted or stalled");

  chk_erase_prog_len: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!busy_reg && cmd_done && cmd_kind == CMD_BEGIN_EP) |=>
      busy_reg && busy_cnt_reg == CNT_W'(ERASE_CYC + PROG_CYC))
    else $error("erase and program time wrong");

  chk_lv_holds: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && lv_mode_reg && pins_s2_reg.sel && pins_s2_reg.lv) |=> lv_mode_reg)
    else $error("low-voltage mode dropped");
endmodule

`default_nettype wire

// ### testbench/spvp_prog.sv
// spvp_prog: programmer model driving the serial clock and data pins
`timescale 1ns/100ps
`default_nettype none
module spvp_prog (
  input  wire logic        ref_clk_i,
  input  wire logic        line_i,
  input  wire logic        oe_n_i,
  output logic             sclk_o,
  output logic             sdat_o,
  output logic [15:0]      rd_o,
  output logic [15:0]      oe_o
);
  initial begin
    sclk_o = 1'b0;
    sdat_o = 1'b0;
  end
  // one bit, 400 ns; a released line toggles so stale data never passes for a reply
  task automatic put(input logic b, input logic rel);
    @(posedge ref_clk_i);
    sclk_o <= 1'b1;
    sdat_o <= rel ? ~sdat_o : b;
    repeat (4) @(posedge ref_clk_i);
    rd_o = {line_i, rd_o[15:1]};
    oe_o = {oe_n_i, oe_o[15:1]};
    sclk_o <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
  endtask
  // clock stands low between frames; data is driven low there for mode entry
  task automatic frame(input logic [5:0] cmd, input logic [15:0] d, input int n, input logic rel);
    for (int i = 0; i < 6; i++) put(cmd[i], 1'b0);
    repeat (20) @(posedge ref_clk_i);
    for (int i = 0; i < n; i++) put(d[i], rel);
    repeat (20) @(posedge ref_clk_i);
    sdat_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### testbench/test_serial_program_verify_port.sv
// test_serial_program_verify_port: self-checking bench for the program/verify port
`timescale 1ns/100ps
`default_nettype none
module test_serial_program_verify_port;
  import spvp_pkg::*;
  logic        ref_clk, rst, ce, hv, sel, lv, sclk, sdat, d_o, oe_n, pv, lvm, busy, line;
  logic [15:0] rd, oe;
  int          err_count, cmp_count;
  // the device owns the wire only while its enable is low
  assign line = oe_n ? sdat : d_o;
  localparam int T_ERASE = 20;
  localparam int T_PROG  = 20;
  spvp_port #(.ERASE_CYC(T_ERASE), .PROG_CYC(T_PROG)) i_dut (
    .ref_clk_i(ref_clk), .rst_i(rst), .ce_i(ce), .mode_hv_i(hv), .mode_select_pin_i(sel),
    .low_voltage_entry_pin_i(lv), .serial_clock_pin_i(sclk), .serial_data_pin_i(line),
    .serial_data_pin_o(d_o), .serial_data_pin_oe_n_o(oe_n), .pv_mode_o(pv),
    .low_voltage_programming_mode_o(lvm), .busy_o(busy));
  spvp_prog i_prog (.ref_clk_i(ref_clk), .line_i(line), .oe_n_i(oe_n), .sclk_o(sclk),
    .sdat_o(sdat), .rd_o(rd), .oe_o(oe));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    if (err_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic cmd(input logic [3:0] op);
    i_prog.frame({2'b00, op}, 16'h0000, 0, 1'b0);
  endtask
  task automatic load(input logic [3:0] op, input logic [13:0] w);
    i_prog.frame({2'b00, op}, {1'b0, w, 1'b0}, 16, 1'b0);
  endtask
  // busy is looked at from the decode edge on, off the clock edge, and its length counted
  task automatic go(input logic [5:0] op, input logic b);
    int n;
    for (int i = 0; i < 6; i++) i_prog.put(op[i], 1'b0);
    @(negedge ref_clk);
    chk(16'(busy), 16'h0001);
    for (n = 0; n < 80 && busy !== 1'b0; n++) @(negedge ref_clk);
    chk(16'(busy), 16'h0000);
    chk(16'(n), b ? 16'(T_ERASE + T_PROG) : 16'(T_PROG));
  endtask
  task automatic rdw(input logic [3:0] op, input logic [13:0] w);
    i_prog.frame({2'b00, op}, 16'h0000, 16, 1'b1);
    chk(16'(rd[14:1]), 16'(w));
    chk(oe, 16'h0001);
    chk(16'(oe_n), 16'h0001);
  endtask
  task automatic enter_hv;
    hv <= 1'b0;
    repeat (8) @(posedge ref_clk);
    hv <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk(16'({pv, lvm}), 16'h0002);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_config;
    enter_hv();
    load(OP_LD_CFG, 14'h3FFF);
    for (int i = 0; i < 7; i++) cmd(OP_INC);
    go(OP_BEGIN_EP, 1'b1);
    rdw(OP_RD_PM, 14'h3FFF);
  endtask
  task automatic t_lowv;
    hv <= 1'b0;
    sel <= 1'b1;
    lv <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk(16'({pv, lvm}), 16'h0003);
    hv <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk(16'({pv, lvm}), 16'h0003);
    lv <= 1'b0;
    sel <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk(16'({pv, lvm}), 16'h0002);
  endtask
  task automatic t_words;
    load(OP_LD_PM, 14'h1234);
    go(OP_BEGIN_EP, 1'b1);
    cmd(OP_INC);
    load(OP_LD_PM, 14'h0ABC);
    go(OP_BEGIN_EP, 1'b1);
    rdw(OP_RD_PM, 14'h0ABC);
    load(OP_LD_DM, 14'h005A);
    go(OP_BEGIN_EP, 1'b1);
    rdw(OP_RD_DM, 14'h005A);
    enter_hv();
    rdw(OP_RD_PM, 14'h1234);
    cmd(OP_BE_PM);
    rdw(OP_RD_PM, 14'h3FFF);
    load(OP_LD_PM, 14'h0F0F);
    go(OP_BEGIN_P, 1'b0);
    rdw(OP_RD_PM, 14'h0F0F);
    cmd(OP_BE_DM);
    rdw(OP_RD_DM, 14'h00FF);
    i_prog.frame(OP_SETUP2, 16'h0000, 0, 1'b0);
    rdw(OP_RD_PM, 14'h0F0F);
    i_prog.frame(OP_SETUP1, 16'h0000, 0, 1'b0);
    i_prog.frame(OP_SETUP2, 16'h0000, 0, 1'b0);
    rdw(OP_RD_PM, 14'h3FFF);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    {rst, ce, hv, sel, lv} = 5'b11000;
    err_count = 0;
    cmp_count = 0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk(16'({pv, lvm, busy, oe_n}), 16'h0001);
    t_config();
    t_lowv();
    t_words();
    stop_test();
  end
  // the whole run needs well under a fifth of this
  initial begin
    repeat (60000) @(posedge ref_clk);
    err_count++;
    stop_test();
  end
endmodule
`default_nettype wire
